// ===== design/dwg_params.svh
// constants for the guard timer: register offset, field layout, timing
// assumes a 100 MHz system clock and an 8-bit data-space register port
`ifndef DWG_PARAMS_SVH
`define DWG_PARAMS_SVH

`define DWG_REG_ADDR       8'hd8
`define DWG_REG_RESET      8'hfe
`define DWG_ARM_BIT        0
`define DWG_TRIG_BIT       1
`define DWG_CHAIN_W        7
`define DWG_PRESCALE       3072
`define DWG_PRESCALE_W     12
`define DWG_STAB_CYCLES    2048
`define DWG_STAB_W         12
`define DWG_GRACE_INSTR    28
`define DWG_GRACE_W        6

`endif

// ===== design/dwg_pkg.sv
// types shared by the guard timer files
// assumes dwg_params.svh is on the include path
`default_nettype none
package dwg_pkg;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } dwg_bus_s;

  typedef enum logic [1:0] {
    DWG_ST_IDLE  = 2'b00,
    DWG_ST_ARMED = 2'b01,
    DWG_ST_FIRE  = 2'b10
  } dwg_state_e;

  typedef struct packed {
    logic       pin_meta;
    logic       pin_sync;
    logic [11:0] cnt;
  } dwg_stab_s;

endpackage : dwg_pkg
`default_nettype wire

// ===== design/dwg_reset_stretch.sv
// reset stabilisation stretcher: holds the internal reset for a fixed
// number of cycles after every reset cause has gone away
// assumes the watchdog cause is active high and the pin is active low and asynchronous
`include "dwg_params.svh"
`default_nettype none
module dwg_reset_stretch #(
  parameter int STAB_CYCLES = `DWG_STAB_CYCLES
) (
  // clock and power-on reset
  input  wire logic i_mclk,
  input  wire logic i_nrst,
  // reset causes
  input  wire logic i_pin_rst_n,
  input  wire logic i_wdg_fire,
  // stretched reset
  output logic      o_hold
);

  dwg_pkg::dwg_stab_s st_r;
  dwg_pkg::dwg_stab_s st_nxt;
  logic               hold_r;
  logic               hold_nxt;

  always_comb begin
    st_nxt          = st_r;
    st_nxt.pin_meta = i_pin_rst_n;
    st_nxt.pin_sync = st_r.pin_meta;
    hold_nxt        = hold_r;
    if (!st_r.pin_sync || i_wdg_fire) begin
      st_nxt.cnt = '0;
      hold_nxt   = 1'b1;
    end else if (hold_r) begin
      if (st_r.cnt == 12'(STAB_CYCLES - 1)) begin
        hold_nxt = 1'b0;
      end else begin
        st_nxt.cnt = st_r.cnt + 12'h001;
      end
    end
  end

  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      st_r   <= '0;
      hold_r <= 1'b1;
    end else begin
      st_r   <= st_nxt;
      hold_r <= hold_nxt;
    end
  end

  assign o_hold = hold_r;

endmodule : dwg_reset_stretch
`default_nettype wire

// ===== design/dwg_guard.sv
// digital watchdog: reloadable down counter that resets the device
// assumes a core that does single-cycle register reads and writes and
// pulses i_instr_done once per retired instruction
//
// Notes on behaviour
// - count down, reset device on expiry
// - software option: inactive until arm bit
// - once armed, only reset disarms
// - stop allowed only while inactive
// - hardware option: always on, stop acts wait
// - resume counting after stop wake
// - register loads 0xfe on reset
// - trigger bit falling resets the device
// - count bits stored in reversed order
// - 64 periods, 3072 to 196608 cycles
// - hardware option: arm bit reads one
// - unarmed: free 7-bit timer, no expiry reset; a trigger-bit clear still resets
// - 28 instructions before first reset; only the expiry reset waits for them, a trigger-bit clear resets at once
// - watchdog reset like pin reset
// - stabilisation holds reset 2048 cycles
`include "dwg_params.svh"
`default_nettype none
module dwg_guard #(
  parameter int PRESCALE    = `DWG_PRESCALE,
  parameter int STAB_CYCLES = `DWG_STAB_CYCLES,
  parameter int GRACE_INSTR = `DWG_GRACE_INSTR
) (
  // clock and power-on reset
  input  wire logic       i_mclk,
  input  wire logic       i_nrst,
  // mask option: high selects hardware activation
  input  wire logic       i_hw_option,
  // external reset pin, active low, asynchronous
  input  wire logic       i_pin_rst_n,
  // core data-space port
  input  wire logic       i_wr,
  input  wire logic       i_rd,
  input  wire logic [7:0] i_addr,
  input  wire logic [7:0] i_wdata,
  output logic      [7:0] o_rdata,
  // core status
  input  wire logic       i_instr_done,
  input  wire logic       i_stop_req,
  input  wire logic       i_wake,
  // power and reset controls
  output logic            o_osc_stop,
  output logic            o_wait_mode,
  output logic            o_dev_rst
);

  typedef struct packed {
    logic [6:0]  chain;
    logic        arm;
    logic        opt;
    logic [11:0] pre;
    logic [5:0]  grace;
    logic        fire;
    logic        osc_stop;
    logic        wait_mode;
    logic [7:0]  rdata;
    logic        dev_rst;
    dwg_pkg::dwg_state_e st;
  } dwg_core_s;

  dwg_core_s        s_r;
  dwg_core_s        s_nxt;
  dwg_pkg::dwg_bus_s bus;
  logic             hold;
  logic             active;
  logic             hit;
  logic [6:0]       wr_chain;

  function automatic logic [6:0] reg_to_chain(input logic [7:0] r);
    logic [6:0] c;
    c = '0;
    for (int i = 0; i < 6; i++) begin
      c[i] = r[7 - i];
    end
    c[6] = r[`DWG_TRIG_BIT];
    return c;
  endfunction : reg_to_chain

  function automatic logic [7:0] chain_to_reg(input logic [6:0] c,
                                              input logic       a);
    logic [7:0] r;
    r = '0;
    for (int i = 0; i < 6; i++) begin
      r[7 - i] = c[i];
    end
    r[`DWG_TRIG_BIT] = c[6];
    r[`DWG_ARM_BIT]  = a;
    return r;
  endfunction : chain_to_reg

  assign bus.wr    = i_wr;
  assign bus.rd    = i_rd;
  assign bus.addr  = i_addr;
  assign bus.wdata = i_wdata;
  assign hit       = (bus.addr == `DWG_REG_ADDR);
  assign wr_chain  = reg_to_chain(bus.wdata);
  assign active    = s_r.arm | s_r.opt;

  // same stretched release as the pin
  dwg_reset_stretch #(
    .STAB_CYCLES (STAB_CYCLES)
  ) u_stretch (
    .i_mclk      (i_mclk),
    .i_nrst      (i_nrst),
    .i_pin_rst_n (i_pin_rst_n),
    .i_wdg_fire  (s_r.fire),
    .o_hold      (hold)
  );

  always_comb begin
    s_nxt      = s_r;
    s_nxt.fire = 1'b0;
    // registered so the output never glitches while fire and hold hand over
    s_nxt.dev_rst = hold | s_r.fire;
    if (hold) begin
      // reset image 0xfe, option sampled after reset
      s_nxt.chain     = reg_to_chain(`DWG_REG_RESET);
      s_nxt.arm       = 1'b0;
      s_nxt.opt       = i_hw_option;
      s_nxt.pre       = '0;
      s_nxt.grace     = '0;
      s_nxt.osc_stop  = 1'b0;
      s_nxt.wait_mode = 1'b0;
      s_nxt.st        = i_hw_option ? dwg_pkg::DWG_ST_ARMED
                                    : dwg_pkg::DWG_ST_IDLE;
    end else begin
      // prescaler, frozen while oscillator is stopped
      if (!s_r.osc_stop) begin
        if (s_r.pre == 12'(PRESCALE - 1)) begin
          s_nxt.pre = '0;
          s_nxt.chain = s_r.chain - 7'h01;
        end else begin
          s_nxt.pre = s_r.pre + 12'h001;
        end
      end
      if (active && i_instr_done && s_r.grace != 6'(GRACE_INSTR)) begin
        s_nxt.grace = s_r.grace + 6'h01;
      end
      if (bus.wr && hit) begin
        s_nxt.chain = wr_chain;
        s_nxt.pre   = '0;
        // arm on write of one, never cleared by write
        if (bus.wdata[`DWG_ARM_BIT] && !s_r.arm && !s_r.opt) begin
          s_nxt.arm   = 1'b1;
          s_nxt.grace = '0;
          s_nxt.st    = dwg_pkg::DWG_ST_ARMED;
        end
      end
      case (s_r.st)
        dwg_pkg::DWG_ST_IDLE: begin
          if (bus.wr && hit && s_r.chain[6] && !wr_chain[6]) begin
            s_nxt.st = dwg_pkg::DWG_ST_FIRE;
          end
        end
        dwg_pkg::DWG_ST_ARMED: begin
          if (bus.wr && hit && s_r.chain[6] && !wr_chain[6]) begin
            s_nxt.st = dwg_pkg::DWG_ST_FIRE;
          end else if (s_r.chain[6] && !s_nxt.chain[6] &&
                       s_r.grace == 6'(GRACE_INSTR)) begin
            s_nxt.st = dwg_pkg::DWG_ST_FIRE;
          end
        end
        dwg_pkg::DWG_ST_FIRE: begin
          s_nxt.fire = 1'b1;
        end
        default: begin
          s_nxt.st = dwg_pkg::DWG_ST_IDLE;
        end
      endcase
      // stop halts the oscillator only when inactive
      // wake resumes from the kept count
      if (i_wake) begin
        s_nxt.osc_stop  = 1'b0;
        s_nxt.wait_mode = 1'b0;
      end else if (i_stop_req) begin
        s_nxt.osc_stop  = !active;
        s_nxt.wait_mode = active;
      end
    end
    // arm reads one under hardware option
    s_nxt.rdata = (bus.rd && hit)
                ? chain_to_reg(s_r.chain, s_r.arm | s_r.opt) : 8'h00;
  end

  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      s_r         <= '0;
      s_r.chain   <= 7'h7f;
      s_r.dev_rst <= 1'b1;
      s_r.st      <= dwg_pkg::DWG_ST_IDLE;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign o_rdata     = s_r.rdata;
  assign o_osc_stop  = s_r.osc_stop;
  assign o_wait_mode = s_r.wait_mode;
  assign o_dev_rst   = s_r.dev_rst;

endmodule : dwg_guard
`default_nettype wire

// ===== sim/dwg_guard_asserts.sv
// port checker for the guard timer
// assumes one clock domain and bench writes only outside device reset
`default_nettype none
module dwg_guard_asserts (
  // clock and reset
  input wire logic       i_mclk,
  input wire logic       i_nrst,
  // inputs
  input wire logic       i_hw_option,
  input wire logic       i_wr,
  input wire logic       i_rd,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic       i_stop_req,
  input wire logic       i_wake,
  // outputs
  input wire logic [7:0] o_rdata,
  input wire logic       o_osc_stop,
  input wire logic       o_wait_mode,
  input wire logic       o_dev_rst
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_nrst);
  logic wr_hit;
  assign wr_hit = i_wr && i_addr == 8'hd8;
  a_rst_stretch: assert property ($rose(i_nrst) |-> o_dev_rst [*8])
    else $error("stretch too short");
  a_fire_hold: assert property ($rose(o_dev_rst) |-> o_dev_rst [*8])
    else $error("device reset too short");
  a_trig_fire: assert property (
    $past(wr_hit && i_wdata[1]) && wr_hit && !i_wdata[1] && !o_dev_rst
    |-> ##3 o_dev_rst) else $error("trigger clear did not reset");
  a_rd_idle: assert property (
    !($past(i_rd) && $past(i_addr) == 8'hd8) |-> o_rdata == 8'h00)
    else $error("read data not zero");
  a_hw_arm_one: assert property (
    i_hw_option && $past(i_rd && i_addr == 8'hd8 && !o_dev_rst)
    |-> o_rdata[0]) else $error("arm bit low in hw option");
  a_hw_no_stop: assert property (i_hw_option |-> !o_osc_stop)
    else $error("oscillator stopped in hw option");
  a_stop_wait: assert property (
    i_stop_req && i_hw_option && !o_dev_rst |=> o_wait_mode)
    else $error("stop not taken as wait");
  a_wake_clear: assert property (
    i_wake && !o_dev_rst |=> !o_osc_stop && !o_wait_mode)
    else $error("wake left stop state");
endmodule : dwg_guard_asserts
bind dwg_guard dwg_guard_asserts u_chk (.i_mclk, .i_nrst, .i_hw_option,
  .i_wr, .i_rd, .i_addr, .i_wdata, .i_stop_req, .i_wake, .o_rdata,
  .o_osc_stop, .o_wait_mode, .o_dev_rst);
`default_nettype wire

// ===== sim/tb.sv
// self-checking bench for the guard timer
// assumes short counts: prescale 8, stretch 16, grace 2
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic       i_mclk, i_nrst, i_hw_option, i_pin_rst_n;
  logic       i_wr, i_rd, i_instr_done, i_stop_req, i_wake;
  logic [7:0] i_addr, i_wdata, o_rdata;
  logic       o_osc_stop, o_wait_mode, o_dev_rst;
  int         mismatches, total_checks, n;
  dwg_guard #(.PRESCALE(8), .STAB_CYCLES(16), .GRACE_INSTR(2)) u_dwg_guard (
    .i_mclk, .i_nrst, .i_hw_option, .i_pin_rst_n, .i_wr, .i_rd, .i_addr,
    .i_wdata, .o_rdata, .i_instr_done, .i_stop_req, .i_wake, .o_osc_stop,
    .o_wait_mode, .o_dev_rst);
  initial begin
    i_mclk = 0;
    forever #5 i_mclk = ~i_mclk;
  end
  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : close_out
  task automatic check(input string what, input logic [7:0] got, exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic cyc(input int k);
    repeat (k) @(negedge i_mclk);
  endtask : cyc
  // hold keeps the strobe up so a second write follows back to back
  task automatic wr(input logic [7:0] d, input bit hold);
    i_wr = 1;
    i_addr = 8'hd8;
    i_wdata = d;
    cyc(1);
    if (!hold) i_wr = 0;
  endtask : wr
  task automatic rd(input logic [7:0] a, exp, input string what);
    i_rd = 1;
    i_addr = a;
    cyc(1);
    check(what, o_rdata, exp);
    i_rd = 0;
    // one idle cycle so a following call never re-drives in this step
    cyc(1);
  endtask : rd
  task automatic wait_rst(input logic lvl, input int lim);
    n = 0;
    while (o_dev_rst !== lvl && n < lim) begin
      cyc(1);
      n++;
    end
    if (n >= lim) begin
      mismatches++;
      $display("[ERR] dev_rst expected %b seen %b", lvl, o_dev_rst);
      close_out();
    end
  endtask : wait_rst
  task automatic pm(input bit stop, input logic [1:0] exp, input string s);
    if (stop) i_stop_req = 1;
    else i_wake = 1;
    cyc(1);
    if (stop) i_stop_req = 0;
    else i_wake = 0;
    check(s, {6'h00, o_osc_stop, o_wait_mode}, {6'h00, exp});
  endtask : pm
  task automatic do_reset();
    i_nrst = 0;
    cyc(12);
    i_nrst = 1;
    wait_rst(0, 100);
  endtask : do_reset
  initial begin
    {i_hw_option, i_wr, i_rd, i_instr_done, i_stop_req} = '0;
    {i_wake, i_addr, i_wdata, i_pin_rst_n} = 18'h1;
    {mismatches, total_checks} = '0;
    do_reset();
    rd(8'hd8, 8'hfe, "reset value");
    rd(8'hd9, 8'h00, "unmapped");
    wr(8'h82, 0);
    cyc(10);
    rd(8'hd8, 8'h02, "timer step");
    cyc(7);
    rd(8'hd8, 8'hfc, "timer wrap");
    check("no fire", {7'h00, o_dev_rst}, 8'h00);
    pm(1, 2'b10, "stop off");
    pm(0, 2'b00, "wake off");
    $display("done: register and timer");
    wr(8'h07, 1);
    wr(8'h06, 0);
    rd(8'hd8, 8'h07, "stays armed");
    pm(1, 2'b01, "stop armed");
    pm(0, 2'b00, "wake armed");
    wr(8'h06, 1);
    wr(8'h04, 0);
    cyc(3);
    check("trig fire", {7'h00, o_dev_rst}, 8'h01);
    wait_rst(0, 100);
    check("hold", {7'h00, n >= 16}, 8'h01);
    $display("done: arm and trigger");
    wr(8'h03, 0);
    repeat (3) begin
      i_instr_done = 1;
      cyc(1);
      i_instr_done = 0;
      cyc(1);
    end
    wait_rst(1, 40);
    // write edge + 8 prescale cycles + 2 to the pin, wait began 6 in
    check("expiry", n[7:0], 8'h04);
    wait_rst(0, 100);
    wr(8'h03, 0);
    cyc(40);
    check("grace", {7'h00, o_dev_rst}, 8'h00);
    $display("done: expiry and grace");
    i_hw_option = 1;
    do_reset();
    wr(8'h82, 0); // reload inside grace
    rd(8'hd8, 8'h83, "hw arm");
    pm(1, 2'b01, "hw stop");
    pm(0, 2'b00, "hw wake");
    i_pin_rst_n = 0;
    cyc(2);
    i_pin_rst_n = 1;
    wait_rst(1, 10);
    wait_rst(0, 100);
    check("pin hold", {7'h00, n >= 16}, 8'h01);
    $display("done: hardware option");
    close_out();
  end
endmodule : tb
`default_nettype wire
